// ---- pkg/tdm_fifo_pkg.sv ----
// constants, slot codes and carriers for the time-sliced fifo memory
package tdm_fifo_pkg;
  // ==================================================================
  // memory geometry, 64-bit words
  localparam int         DATA_W          = 64;
  localparam int         ADDR_W          = 9;
  localparam int         MEM_WORDS       = 432;
  localparam int         NUM_FIFOS       = 3;
  localparam logic [8:0] RX_BASE         = 9'h000;
  localparam logic [8:0] RX_WORDS        = 9'h0c0;
  localparam logic [8:0] TX0_BASE        = 9'h0c0;
  localparam logic [8:0] TX1_BASE        = 9'h120;
  localparam logic [8:0] TX_WORDS        = 9'h060;
  localparam logic [8:0] TX_MERGED_WORDS = 9'h0c0;
  localparam logic [8:0] LIST_BASE       = 9'h180;
  localparam logic [8:0] LAST_WORD       = 9'h1af;
  localparam logic [1:0] LIST_COUNT      = 2'h3;
  localparam logic [8:0] PTR_RESET       = 9'h000;
  localparam logic [8:0] COUNT_RESET     = 9'h000;

  // ==================================================================
  // slot schedule and access targets
  typedef enum logic [3:0] {
    SLOT_HOST_A = 4'b0001,
    SLOT_NET    = 4'b0010,
    SLOT_HOST_B = 4'b0100,
    SLOT_SPARE  = 4'b1000
  } slot_e;

  typedef enum logic [2:0] {
    OWN_HOST = 3'b001,
    OWN_NET  = 3'b010,
    OWN_DIAG = 3'b100
  } owner_e;

  typedef enum logic [2:0] {
    TGT_RX   = 3'h0,
    TGT_TX0  = 3'h1,
    TGT_TX1  = 3'h2,
    TGT_LIST = 3'h3,
    TGT_RAW  = 3'h4
  } target_e;

  // ==================================================================
  // carriers
  typedef struct packed {
    logic                valid;
    logic                write;
    target_e             target;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
  } req_s;

  typedef struct packed {
    logic                valid;
    logic [DATA_W-1:0]   data;
  } resp_s;
endpackage

// ---- verilog/tdm_fifo_sram.sv ----
// time-sliced fifo memory with per-fifo pointer and counter registers
// ==================================================================
// Overview of operation
// RULE1 - all memory ports run on host bus clock
// RULE2 - fixed rotating slot schedule, no arbiter
// RULE3 - host side gets every other slot, 64-bit
// RULE4 - protocol handler gets one quarter, 64-bit
// RULE5 - spare quarter may go to protocol handler
// RULE6 - receive, two transmit fifos, three list areas
// RULE7 - one-channel mode merges transmit regions
// RULE8 - pointers and counters locate data and fill
// RULE9 - separate pointer sets for each fifo
// RULE10 - diagnostic port reads and writes raw memory
// RULE11 - host uses mapped i/o for registers, test; code has no register map, raw access is diag-port only
// RULE12 - pointers wrap at region end, counter tracks
`timescale 1ns/1ns
`default_nettype none
module tdm_fifo_sram
  import tdm_fifo_pkg::*;
(
  input  wire logic                      clk_in,
  input  wire logic                      reset_n_in,
  input  wire logic                      one_channel_in,
  input  wire logic                      extra_bw_in,
  input  wire req_s                      host_req_in,
  input  wire req_s                      net_req_in,
  input  wire req_s                      diag_req_in,
  output var  resp_s                     host_resp_out,
  output var  resp_s                     net_resp_out,
  output var  resp_s                     diag_resp_out,
  output var  logic [NUM_FIFOS-1:0][8:0] fifo_level_out
);

  // ==================================================================
  // storage and pointer state
  logic [DATA_W-1:0] mem [MEM_WORDS];
  slot_e             slot;
  owner_e            owner;
  req_s              sel;
  logic              acc_ok;
  logic [8:0]        acc_addr;
  logic [1:0]        fidx;
  logic              is_fifo;
  logic [8:0]        wr_ptr [NUM_FIFOS];
  logic [8:0]        rd_ptr [NUM_FIFOS];
  logic [8:0]        count  [NUM_FIFOS];

  // region sizes follow the channel mode; tx1 vanishes when merged
  function automatic logic [8:0] region_size(input int i, input logic one_ch);
    logic [8:0] s;
    s = TX_WORDS;
    if (i == 0)
      s = RX_WORDS;
    else if (one_ch)
      s = (i == 1) ? TX_MERGED_WORDS : 9'h000;
    return s;
  endfunction

  function automatic logic [8:0] region_base(input int i);
    logic [8:0] b;
    b = (i == 0) ? RX_BASE : ((i == 1) ? TX0_BASE : TX1_BASE);
    return b;
  endfunction

  // ==================================================================
  // slot rotation
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      slot <= SLOT_HOST_A;
    else
      slot <= slot_e'({slot[2:0], slot[3]}); // RULE2
  end

  always_comb
  begin
    sel   = host_req_in;
    owner = OWN_HOST;
    unique case (slot)
      SLOT_HOST_A, SLOT_HOST_B:
      begin
        sel   = host_req_in; // RULE3
        owner = OWN_HOST;
      end
      SLOT_NET:
      begin
        sel   = net_req_in; // RULE4
        owner = OWN_NET;
      end
      SLOT_SPARE:
      begin
        // diagnostics get every spare slot unless extra bandwidth is on and the handler has a request pending
        if (extra_bw_in && net_req_in.valid)
        begin
          sel   = net_req_in; // RULE5
          owner = OWN_NET;
        end
        else
        begin
          sel   = diag_req_in; // RULE10
          owner = OWN_DIAG;
        end
      end
    endcase
  end

  // ==================================================================
  // access decode: fifo, list or raw word
  always_comb
  begin
    fidx     = sel.target[1:0];
    is_fifo  = (sel.target == TGT_RX) || (sel.target == TGT_TX0) || (sel.target == TGT_TX1);
    acc_ok   = 1'b0;
    acc_addr = sel.addr;
    if (is_fifo && fidx != 2'h3)
    begin
      acc_addr = sel.write ? wr_ptr[fidx] : rd_ptr[fidx]; // RULE8
      // full or empty refuses; merged tx1 has size zero so is always refused
      acc_ok   = sel.valid && (sel.write ? (count[fidx] != region_size(int'(fidx), one_channel_in))
                                         : (count[fidx] != COUNT_RESET)); // RULE7
    end
    else if (sel.target == TGT_LIST)
    begin
      acc_addr = LIST_BASE + {3'h0, sel.addr[5:0]}; // RULE6
      acc_ok   = sel.valid && (sel.addr[5:4] != LIST_COUNT);
    end
    else if (sel.target == TGT_RAW)
      acc_ok = sel.valid && (owner == OWN_DIAG) && (sel.addr <= LAST_WORD); // RULE10
  end

  // ==================================================================
  // memory array, single clock
  always_ff @(posedge clk_in)
  begin
    if (acc_ok && sel.write)
      mem[acc_addr] <= sel.data; // RULE1
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      host_resp_out <= '0;
      net_resp_out  <= '0;
      diag_resp_out <= '0;
    end
    else
    begin
      host_resp_out.valid <= acc_ok && (owner == OWN_HOST); // RULE3
      net_resp_out.valid  <= acc_ok && (owner == OWN_NET); // RULE4
      diag_resp_out.valid <= acc_ok && (owner == OWN_DIAG);
      if (acc_ok && !sel.write)
      begin
        host_resp_out.data <= mem[acc_addr];
        net_resp_out.data  <= mem[acc_addr];
        diag_resp_out.data <= mem[acc_addr];
      end
    end
  end

  // ==================================================================
  // per-fifo pointer and counter registers
  genvar gi;
  generate
    for (gi = 0; gi < NUM_FIFOS; gi++)
    begin : g_fifo
      logic       hit;
      logic [8:0] last;
      assign hit  = acc_ok && is_fifo && (fidx == 2'(gi));
      assign last = region_base(gi) + region_size(gi, one_channel_in) - 9'h001;

      always_ff @(posedge clk_in or negedge reset_n_in)
      begin
        if (!reset_n_in)
        begin
          wr_ptr[gi] <= region_base(gi); // RULE9
          rd_ptr[gi] <= region_base(gi);
          count[gi]  <= COUNT_RESET;
        end
        else if (hit && sel.write)
        begin
          wr_ptr[gi] <= (wr_ptr[gi] == last) ? region_base(gi) : wr_ptr[gi] + 9'h001; // RULE12
          count[gi]  <= count[gi] + 9'h001;
        end
        else if (hit)
        begin
          rd_ptr[gi] <= (rd_ptr[gi] == last) ? region_base(gi) : rd_ptr[gi] + 9'h001; // RULE12
          count[gi]  <= count[gi] - 9'h001;
        end
      end
      assign fifo_level_out[gi] = count[gi];
    end
  endgenerate

  // ==================================================================
  // checks
  sequence s_host_pair;
    slot == SLOT_HOST_A ##2 slot == SLOT_HOST_B;
  endsequence

  property p_slot_rotate;
    @(posedge clk_in) disable iff (!reset_n_in)
      slot == SLOT_HOST_A |=> slot == SLOT_NET ##1 slot == SLOT_HOST_B ##1 slot == SLOT_SPARE;
  endproperty
  a_slot_rotate: assert property (p_slot_rotate) else $error("slot order broken"); // RULE2

  property p_host_half;
    @(posedge clk_in) disable iff (!reset_n_in) slot == SLOT_HOST_A |-> s_host_pair;
  endproperty
  a_host_half: assert property (p_host_half) else $error("host slot spacing wrong"); // RULE3

  property p_host_only_own;
    @(posedge clk_in) disable iff (!reset_n_in)
      host_resp_out.valid |-> $past(slot) inside {SLOT_HOST_A, SLOT_HOST_B};
  endproperty
  a_host_only_own: assert property (p_host_only_own) else $error("host served off slot"); // RULE3

  property p_net_slot;
    @(posedge clk_in) disable iff (!reset_n_in)
      net_resp_out.valid |-> $past(slot) inside {SLOT_NET, SLOT_SPARE};
  endproperty
  a_net_slot: assert property (p_net_slot) else $error("handler served off slot"); // RULE4

  property p_spare_to_net;
    @(posedge clk_in) disable iff (!reset_n_in)
      slot == SLOT_SPARE && extra_bw_in && acc_ok && net_req_in.valid |=> net_resp_out.valid;
  endproperty
  a_spare_to_net: assert property (p_spare_to_net) else $error("spare slot not given"); // RULE5

  property p_rx_in_region;
    @(posedge clk_in) disable iff (!reset_n_in) wr_ptr[0] < RX_BASE + RX_WORDS;
  endproperty
  a_rx_in_region: assert property (p_rx_in_region) else $error("rx pointer left region"); // RULE6

  property p_merged_tx1;
    @(posedge clk_in) disable iff (!reset_n_in)
      one_channel_in && sel.target == TGT_TX1 |-> !acc_ok;
  endproperty
  a_merged_tx1: assert property (p_merged_tx1) else $error("tx1 used when merged"); // RULE7

  property p_count_up;
    @(posedge clk_in) disable iff (!reset_n_in)
      g_fifo[0].hit && sel.write |=> count[0] == $past(count[0]) + 9'h001;
  endproperty
  a_count_up: assert property (p_count_up) else $error("count did not rise"); // RULE8

  property p_tx1_in_region;
    @(posedge clk_in) disable iff (!reset_n_in)
      !one_channel_in |-> rd_ptr[2] >= TX1_BASE && rd_ptr[2] < LIST_BASE;
  endproperty
  a_tx1_in_region: assert property (p_tx1_in_region) else $error("tx1 pointer stray"); // RULE9

  property p_diag_answer;
    @(posedge clk_in) disable iff (!reset_n_in)
      slot == SLOT_SPARE && !extra_bw_in && diag_req_in.valid && diag_req_in.target == TGT_RAW
      && diag_req_in.addr <= LAST_WORD |=> diag_resp_out.valid;
  endproperty
  a_diag_answer: assert property (p_diag_answer) else $error("diag access lost"); // RULE10

  property p_wrap;
    @(posedge clk_in) disable iff (!reset_n_in)
      g_fifo[0].hit && sel.write && wr_ptr[0] == RX_BASE + RX_WORDS - 9'h001
      |=> wr_ptr[0] == RX_BASE;
  endproperty
  a_wrap: assert property (p_wrap) else $error("rx pointer did not wrap"); // RULE12

endmodule
`default_nettype wire

// ---- verif/client_model.sv ----
// far-side client model: holds one request until it is answered or 8 edges pass
`timescale 1ns/1ns
`default_nettype none
module client_model
  import tdm_fifo_pkg::*;
(
  input  wire logic  clk_in,
  input  wire resp_s resp_in,
  output var  req_s  req_out
);
  initial req_out = '0;
  // ==================================================================
  // one access; refused requests give up after 8 edges
  task automatic xfer(input logic wr, input target_e t, input logic [8:0] a,
                      input logic [63:0] d, input logic hold,
                      output logic ok, output logic [63:0] q, output int cyc);
    req_out <= '{1'b1, wr, t, a, d};
    cyc = 0;
    ok = 1'b0;
    while (!ok && cyc < 8)
    begin
      @(posedge clk_in);
      cyc++;
      ok = resp_in.valid === 1'b1;
    end
    q = resp_in.data;
    // released lines never keep the old request
    // one idle edge after release keeps the next launch out of this step
    if (!hold)
    begin
      req_out <= '{1'b0, ~wr, t, ~a, ~d};
      @(posedge clk_in);
    end
  endtask
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
// self-checking bench for the time-sliced fifo memory
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import tdm_fifo_pkg::*;
;
  logic                      clk_in = 0;
  logic                      reset_n_in = 0;
  logic                      one_ch = 0;
  logic                      xbw = 0;
  req_s                      hr, nr, gr;
  resp_s                     hs, ns, gs;
  logic [NUM_FIFOS-1:0][8:0] lvl;
  int                        n_errors = 0, num_checks = 0, cycles = 0, cyc;
  logic                      ok;
  logic [63:0]               q, r, w [$];
  logic [63:0]               m [3][$];

  always #5 clk_in = ~clk_in;
  tdm_fifo_sram dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .one_channel_in(one_ch),
    .extra_bw_in(xbw), .host_req_in(hr), .net_req_in(nr), .diag_req_in(gr),
    .host_resp_out(hs), .net_resp_out(ns), .diag_resp_out(gs), .fifo_level_out(lvl));
  client_model h (.clk_in(clk_in), .resp_in(hs), .req_out(hr));
  client_model n (.clk_in(clk_in), .resp_in(ns), .req_out(nr));
  client_model g (.clk_in(clk_in), .resp_in(gs), .req_out(gr));

  // ==================================================================
  // compares, access helpers, verdict
  task automatic chk_data(input logic [63:0] e, input logic [63:0] v);
    num_checks++;
    if (v !== e)
    begin
      n_errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, v);
    end
  endtask
  task automatic chk_lvl();
    for (int i = 0; i < 3; i++)
      chk_data(64'(m[i].size()), 64'(lvl[i]));
  endtask
  task automatic acc(input int c, input logic wr, input target_e t, input logic [8:0] a,
                     input logic [63:0] d, input logic hold);
    case (c)
      0: h.xfer(wr, t, a, d, hold, ok, q, cyc);
      1: n.xfer(wr, t, a, d, hold, ok, q, cyc);
      default: g.xfer(wr, t, a, d, hold, ok, q, cyc);
    endcase
  endtask
  // fifo push or pop against the queue model
  task automatic fop(input int c, input logic wr, input int f);
    logic [63:0] d;
    int          cap;
    logic        e;
    d = {$urandom, $urandom};
    cap = (f == 0) ? 192 : one_ch ? ((f == 1) ? 192 : 0) : 96;
    e = wr ? m[f].size() < cap : m[f].size() > 0;
    acc(c, wr, target_e'(f), 9'h000, d, 1'b0);
    chk_data(64'(e), 64'(ok));
    if (ok && wr)
      m[f].push_back(d);
    if (ok && wr)
      w.push_back(d);
    if (ok && !wr)
      chk_data(m[f].pop_front(), q);
    chk_lvl();
  endtask
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // generous ceiling, the run needs roughly 6000 cycles
  always @(posedge clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      n_errors++;
      print_verdict();
    end
  end

  initial
  begin
    void'($urandom(32'ha23f9824));
    repeat (3) @(posedge clk_in);
    reset_n_in <= 1'b1;
    chk_lvl();
    chk_data(64'h0, 64'({hs.valid, ns.valid, gs.valid}));
    repeat (97) fop(0, 1, 1);
    repeat (97) fop(1, 0, 1);
    w.delete();
    repeat (3) fop(0, 1, 1);
    acc(2, 0, TGT_RAW, TX0_BASE, '0, 1'b0);
    chk_data(w[0], q);
    repeat (3) fop(1, 0, 1);
    $display("test fill_wrap done");
    repeat (600) fop($urandom % 2, ($urandom % 3) != 0, $urandom % 3);
    for (int f = 0; f < 3; f++)
      while (m[f].size() > 0)
        fop(f % 2, 0, f);
    fop(0, 0, 0);
    $display("test random_mix done");
    r = {$urandom, $urandom};
    acc(0, 1, TGT_LIST, 9'h025, r, 1'b0);
    acc(2, 0, TGT_RAW, LIST_BASE + 9'h025, '0, 1'b0);
    chk_data(r, q);
    acc(2, 1, TGT_RAW, LAST_WORD, ~r, 1'b0);
    acc(1, 0, TGT_LIST, 9'h02f, '0, 1'b0);
    chk_data(~r, q);
    acc(0, 1, TGT_LIST, 9'h030, r, 1'b0);
    chk_data(64'h0, 64'(ok));
    acc(2, 0, TGT_RAW, LAST_WORD + 9'h001, r, 1'b0);
    chk_data(64'h0, 64'(ok));
    $display("test list_raw done");
    // back-to-back reads show the host's and the handler's slot spacing
    for (int k = 0; k < 3; k++)
    begin
      xbw <= (k == 2);
      for (int i = 0; i < 5; i++)
      begin
        acc(k > 0, 0, TGT_LIST, 9'h025, '0, i < 4);
        chk_data(r, q);
        if (i > 0)
          chk_data((k == 1) ? 64'd4 : 64'd2, 64'(cyc));
      end
    end
    $display("test slot_rate done");
    one_ch <= 1'b1;
    reset_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    reset_n_in <= 1'b1;
    chk_lvl();
    w.delete();
    repeat (193) fop(0, 1, 1);
    fop(0, 1, 2);
    acc(2, 0, TGT_RAW, TX1_BASE, '0, 1'b0);
    chk_data(w[96], q);
    repeat (192) fop(1, 0, 1);
    $display("test one_channel done");
    print_verdict();
  end
endmodule
`default_nettype wire
